// File: rtl/qac_engine.v
// Function-command engine: read memory, write memory and convert.
// Assumes an outside slot layer delivers whole received bytes and
// pulses rd_slot_in once per master read slot; rd_bit_out is the bit
// to drive in that slot (1 releases the line).
`timescale 1ns/1ps
`include "qac_defines.vh"
module qac_engine #(
    parameter integer WAIT_CYC = (`QAC_WAIT_NS + `QAC_CLK_NS - 1) / `QAC_CLK_NS,
    parameter integer BIT_CYC = `QAC_BIT_NS / `QAC_CLK_NS,
    parameter integer OFS_CYC = `QAC_OFS_NS / `QAC_CLK_NS,
    parameter integer FIFO_DEPTH = 8
) (
    input wire clk_in,
    input wire resetn_in,
    input wire bus_reset_in,
    input wire rx_valid_in,
    input wire [7:0] rx_byte_in,
    output wire rx_ready_out,
    input wire rd_slot_in,
    output reg rd_bit_out,
    input wire [15:0] adc_result_in,
    output reg adc_start_out,
    output reg [1:0] adc_chan_out,
    output reg [4:0] adc_bits_out,
    output reg conv_busy_out
);
    localparam [4:0] S_CMD = 5'h00;
    localparam [4:0] S_ALO = 5'h01;
    localparam [4:0] S_AHI = 5'h02;
    localparam [4:0] S_RFETCH = 5'h03;
    localparam [4:0] S_RLOAD = 5'h04;
    localparam [4:0] S_RSEND = 5'h05;
    localparam [4:0] S_RCRC = 5'h06;
    localparam [4:0] S_ONES = 5'h07;
    localparam [4:0] S_WDATA = 5'h08;
    localparam [4:0] S_WCRC = 5'h09;
    localparam [4:0] S_WSTORE = 5'h0a;
    localparam [4:0] S_WFETCH = 5'h0b;
    localparam [4:0] S_WLOAD = 5'h0c;
    localparam [4:0] S_WBACK = 5'h0d;
    localparam [4:0] S_CMASK = 5'h0e;
    localparam [4:0] S_CCTRL = 5'h0f;
    localparam [4:0] S_CCRC = 5'h10;
    localparam [4:0] S_CWAIT = 5'h11;
    localparam [4:0] S_CPRE = 5'h12;
    localparam [4:0] S_COFS = 5'h13;
    localparam [4:0] S_CNEXT = 5'h14;
    localparam [4:0] S_CRDCTL = 5'h15;
    localparam [4:0] S_CRES = 5'h16;
    localparam [4:0] S_CRUN = 5'h17;
    localparam [4:0] S_CST0 = 5'h18;
    localparam [4:0] S_CST1 = 5'h19;
    localparam [4:0] S_CDONE = 5'h1a;
    localparam [4:0] S_HALT = 5'h1b;

    reg [4:0] state_q;
    reg wr_cmd_q;
    reg [15:0] addr_q;
    reg [15:0] crc_q;
    reg [15:0] sh_q;
    reg [3:0] cnt_q;
    reg [7:0] dat_q;
    reg [3:0] mask_q;
    reg [7:0] ctl_q;
    reg [1:0] ch_q;
    reg [4:0] bits_q;
    reg [31:0] tmr_q;
    reg [15:0] res_q;
    reg rd_bit_d;
    reg mem_we;
    reg [4:0] mem_wa;
    reg [7:0] mem_wd;
    reg [4:0] mem_ra;
    reg take;
    wire f_valid;
    wire [7:0] f_byte;
    wire [7:0] mem_rd;
    wire byte_ok = f_valid & take;
    wire [15:0] crc_w;
    wire [15:0] addr_inc = addr_q + 16'h0001;
    wire [15:0] addr_full = {f_byte, addr_q[7:0]};
    wire at_end = (addr_q >= `QAC_ADDR_LAST);
    wire in_map = ((addr_q & ~`QAC_ADDR_MASK) == 16'h0000);
    wire [1:0] pre_pair = ctl_q[{cnt_q[2:1], 1'b0} +: 2];
    wire tmr_bit = (tmr_q == BIT_CYC - 1);

    // CRC-16 reflected form, data shifted in LSB first
    function [15:0] crc_byte;
        input [15:0] c;
        input [7:0] b;
        integer i;
        reg [15:0] t;
        begin
            t = c;
            for (i = 0; i < 8; i = i + 1) begin
                if (t[0] ^ b[i]) begin
                    t = (t >> 1) ^ `QAC_CRC_POLY;
                end else begin
                    t = t >> 1;
                end
            end
            crc_byte = t;
        end
    endfunction

    assign crc_w = crc_byte(crc_q, f_byte);

    qac_fifo #(
        .W(8),
        .D(FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .clear_in(bus_reset_in),
        .in_valid_in(rx_valid_in),
        .in_data_in(rx_byte_in),
        .in_ready_out(rx_ready_out),
        .out_valid_out(f_valid),
        .out_data_out(f_byte),
        .out_ready_in(take)
    );

    qac_mem #(
        .AW(5)
    ) u_mem (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .we_in(mem_we),
        .waddr_in(mem_wa),
        .wdata_in(mem_wd),
        .raddr_in(mem_ra),
        .rdata_out(mem_rd)
    );

    // Bytes are pulled in states that expect one and dropped in S_HALT; elsewhere the
    // FIFO fills and its ready drops back to the slot layer.
    always @* begin
        case (state_q)
            S_CMD, S_ALO, S_AHI, S_WDATA, S_CMASK, S_CCTRL, S_HALT: take = 1'b1;
            default: take = 1'b0;
        endcase
    end

    always @* begin
        mem_we = 1'b0;
        mem_wa = addr_q[4:0];
        mem_wd = dat_q;
        mem_ra = addr_q[4:0];
        case (state_q)
            S_WSTORE: begin
                // Result page and calibration bytes other than power byte 1Ch stay untouched
                mem_we = in_map && (addr_q[4:3] == `QAC_PG_CTRL ||
                    addr_q[4:3] == `QAC_PG_ALARM ||
                    addr_q[4:0] == `QAC_PWR_ADDR);
            end
            S_CPRE: begin
                mem_wa = {2'h0, cnt_q[2:0]};
                mem_we = mask_q[cnt_q[2:1]] &&
                    (pre_pair == `QAC_PAIR_ZEROS ||
                    pre_pair == `QAC_PAIR_ONES);
                mem_wd = (pre_pair == `QAC_PAIR_ONES) ? 8'hff : 8'h00;
            end
            S_CRDCTL, S_CRES: begin
                mem_ra = `QAC_CTRL_BASE + {2'h0, ch_q, 1'b0};
            end
            S_CST0: begin
                mem_we = 1'b1;
                mem_wa = {2'h0, ch_q, 1'b0};
                mem_wd = res_q[7:0];
            end
            S_CST1: begin
                mem_we = 1'b1;
                mem_wa = {2'h0, ch_q, 1'b1};
                mem_wd = res_q[15:8];
            end
            default: begin
                mem_we = 1'b0;
            end
        endcase
    end

    always @* begin
        case (state_q)
            S_RSEND, S_RCRC, S_WCRC, S_WBACK, S_CCRC: rd_bit_d = sh_q[0];
            S_CWAIT, S_CPRE, S_COFS, S_CNEXT, S_CRDCTL,
            S_CRES, S_CRUN, S_CST0, S_CST1: rd_bit_d = 1'b0;
            default: rd_bit_d = 1'b1;
        endcase
    end

    always @(posedge clk_in) begin
        if (!resetn_in || bus_reset_in) begin
            state_q <= S_CMD;
            wr_cmd_q <= 1'b0;
            addr_q <= 16'h0000;
            crc_q <= `QAC_CRC_INIT;
            sh_q <= 16'hffff;
            cnt_q <= 4'h0;
            dat_q <= 8'h00;
            mask_q <= 4'h0;
            ctl_q <= 8'h00;
            ch_q <= 2'h0;
            bits_q <= 5'h00;
            tmr_q <= 32'h0;
            res_q <= 16'h0000;
            rd_bit_out <= 1'b1;
            adc_start_out <= 1'b0;
            adc_chan_out <= 2'h0;
            adc_bits_out <= 5'h00;
            conv_busy_out <= 1'b0;
        end else begin
            rd_bit_out <= rd_bit_d;
            adc_start_out <= 1'b0;
            case (state_q)
                S_CMD: if (byte_ok) begin
                    crc_q <= crc_byte(`QAC_CRC_INIT, f_byte);
                    wr_cmd_q <= (f_byte == `QAC_CMD_WRITE);
                    if (f_byte == `QAC_CMD_READ ||
                        f_byte == `QAC_CMD_WRITE) begin
                        state_q <= S_ALO;
                    end else if (f_byte == `QAC_CMD_CONVERT) begin
                        state_q <= S_CMASK;
                    end else begin
                        state_q <= S_HALT;
                    end
                end
                S_ALO: if (byte_ok) begin
                    addr_q[7:0] <= f_byte;
                    crc_q <= crc_byte(crc_q, f_byte & `QAC_ADDR_LO_MASK);
                    state_q <= S_AHI;
                end
                S_AHI: if (byte_ok) begin
                    addr_q[15:8] <= f_byte;
                    crc_q <= crc_byte(crc_q, f_byte & `QAC_ADDR_HI_MASK);
                    if (wr_cmd_q) begin
                        state_q <= S_WDATA;
                    end else if (addr_full > `QAC_ADDR_LAST) begin
                        state_q <= S_ONES;
                    end else begin
                        state_q <= S_RFETCH;
                    end
                end
                S_RFETCH: state_q <= S_RLOAD;
                S_RLOAD: begin
                    crc_q <= crc_byte(crc_q, mem_rd);
                    sh_q <= {8'hff, mem_rd};
                    cnt_q <= 4'h0;
                    state_q <= S_RSEND;
                end
                S_RSEND: if (rd_slot_in) begin
                    sh_q <= {1'b1, sh_q[15:1]};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'h7) begin
                        cnt_q <= 4'h0;
                        if (addr_q[2:0] == `QAC_PAGE_END) begin
                            sh_q <= ~crc_q;
                            state_q <= S_RCRC;
                        end else begin
                            addr_q <= addr_inc;
                            state_q <= S_RFETCH;
                        end
                    end
                end
                S_RCRC: if (rd_slot_in) begin
                    sh_q <= {1'b1, sh_q[15:1]};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'hf) begin
                        if (at_end) begin
                            state_q <= S_ONES;
                        end else begin
                            addr_q <= addr_inc;
                            crc_q <= `QAC_CRC_INIT;
                            state_q <= S_RFETCH;
                        end
                    end
                end
                S_WDATA: if (byte_ok) begin
                    dat_q <= f_byte;
                    crc_q <= crc_w;
                    sh_q <= ~crc_w;
                    cnt_q <= 4'h0;
                    state_q <= S_WCRC;
                end
                S_WCRC: if (rd_slot_in) begin
                    sh_q <= {1'b1, sh_q[15:1]};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'hf) begin
                        state_q <= S_WSTORE;
                    end
                end
                S_WSTORE: state_q <= S_WFETCH;
                S_WFETCH: state_q <= S_WLOAD;
                S_WLOAD: begin
                    // Locations past the map read back as ones
                    sh_q <= {8'hff, in_map ? mem_rd : 8'hff};
                    cnt_q <= 4'h0;
                    state_q <= S_WBACK;
                end
                S_WBACK: if (rd_slot_in) begin
                    sh_q <= {1'b1, sh_q[15:1]};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'h7) begin
                        if (at_end) begin
                            state_q <= S_ONES;
                        end else begin
                            addr_q <= addr_inc;
                            crc_q <= addr_inc & `QAC_ADDR_MASK;
                            state_q <= S_WDATA;
                        end
                    end
                end
                S_CMASK: if (byte_ok) begin
                    mask_q <= f_byte[3:0];
                    crc_q <= crc_w;
                    state_q <= S_CCTRL;
                end
                S_CCTRL: if (byte_ok) begin
                    ctl_q <= f_byte;
                    crc_q <= crc_w;
                    sh_q <= ~crc_w;
                    cnt_q <= 4'h0;
                    state_q <= S_CCRC;
                end
                S_CCRC: if (rd_slot_in) begin
                    sh_q <= {1'b1, sh_q[15:1]};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'hf) begin
                        tmr_q <= 32'h0;
                        conv_busy_out <= 1'b1;
                        state_q <= S_CWAIT;
                    end
                end
                S_CWAIT: begin
                    tmr_q <= tmr_q + 32'h1;
                    if (tmr_q == WAIT_CYC - 1) begin
                        cnt_q <= 4'h0;
                        state_q <= S_CPRE;
                    end
                end
                S_CPRE: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'h7) begin
                        tmr_q <= 32'h0;
                        state_q <= S_COFS;
                    end
                end
                S_COFS: begin
                    // Start-up offset charged once per command
                    tmr_q <= tmr_q + 32'h1;
                    if (tmr_q == OFS_CYC - 1) begin
                        ch_q <= 2'h0;
                        state_q <= S_CNEXT;
                    end
                end
                S_CNEXT: begin
                    if (mask_q[ch_q]) begin
                        state_q <= S_CRDCTL;
                    end else if (ch_q == 2'h3) begin
                        state_q <= S_CDONE;
                    end else begin
                        ch_q <= ch_q + 2'h1;
                    end
                end
                S_CRDCTL: state_q <= S_CRES;
                S_CRES: begin
                    if (mem_rd[3:0] == `QAC_RC_FULL) begin
                        bits_q <= `QAC_BITS_FULL;
                        adc_bits_out <= `QAC_BITS_FULL;
                    end else begin
                        bits_q <= {1'b0, mem_rd[3:0]};
                        adc_bits_out <= {1'b0, mem_rd[3:0]};
                    end
                    adc_chan_out <= ch_q;
                    adc_start_out <= 1'b1;
                    tmr_q <= 32'h0;
                    state_q <= S_CRUN;
                end
                S_CRUN: begin
                    tmr_q <= tmr_q + 32'h1;
                    if (tmr_bit) begin
                        tmr_q <= 32'h0;
                        bits_q <= bits_q - 5'h01;
                        if (bits_q == 5'h01) begin
                            res_q <= adc_result_in;
                            state_q <= S_CST0;
                        end
                    end
                end
                S_CST0: state_q <= S_CST1;
                S_CST1: begin
                    // Result is in memory now, before later channels
                    if (ch_q == 2'h3) begin
                        state_q <= S_CDONE;
                    end else begin
                        ch_q <= ch_q + 2'h1;
                        state_q <= S_CNEXT;
                    end
                end
                S_CDONE: conv_busy_out <= 1'b0;
                S_ONES, S_HALT: state_q <= state_q;
                default: state_q <= S_HALT;
            endcase
        end
    end
endmodule // qac_engine

// File: rtl/qac_defines.vh
// Shared constants for the quad converter function-command engine.
// Assumes a 200 MHz clock; the slot layer sits outside this block.
// How it works
// - Read command is followed by start address, low byte then high byte.
// - Read slots return bytes to page end, then a 16-bit CRC.
// - First read page CRC covers command, both address bytes and data.
// - Later read pages restart the CRC over that page's data only.
// - Writes change only control page, alarm page and power byte 1Ch.
// - First write pass: command, address, one data byte, then CRC back.
// - After the CRC the byte is stored, then read back over eight slots.
// - Without reset and before memory end, address increments and seeds CRC.
// - Later write passes: one byte in, CRC over sixteen slots, read-back.
// - Result page writes run the full protocol but never change results.
// - A bus reset pulse aborts any command and returns to waiting.
// - Convert starts conversion at each channel's configured resolution.
// - Conversion takes 60 to 80 us per bit plus up to 160 us offset.
// - A channel converts only when its select mask bit is one.
// - Selected channels convert in order A to D; each result lands at once.
// - Selected result registers with pair 01 or 10 are preset to zeros or ones before converting.
// - Read-out control pairs: 00 keep, 01 zeros, 10 ones, 11 illegal.
// - Conversion starts at least 10 us after the last CRC bit.
// - Polling read slots return zeros while busy, ones when finished.
// - Upper eleven address bits enter the CRC as zeros.
`ifndef QAC_DEFINES_VH
`define QAC_DEFINES_VH
`define QAC_CMD_READ 8'haa
`define QAC_CMD_WRITE 8'h55
`define QAC_CMD_CONVERT 8'h3c
`define QAC_CRC_POLY 16'ha001
`define QAC_CRC_INIT 16'h0000
`define QAC_ADDR_MASK 16'h001f
`define QAC_ADDR_LO_MASK 8'h1f
`define QAC_ADDR_HI_MASK 8'h00
`define QAC_ADDR_LAST 16'h001f
`define QAC_PAGE_END 3'h7
`define QAC_PG_CTRL 2'h1
`define QAC_PG_ALARM 2'h2
`define QAC_PWR_ADDR 5'h1c
`define QAC_CTRL_BASE 5'h08
`define QAC_RC_FULL 4'h0
`define QAC_BITS_FULL 5'h10
`define QAC_PAIR_ZEROS 2'h1
`define QAC_PAIR_ONES 2'h2
`define QAC_RST_RESULT 8'h00
`define QAC_RST_CTRL_LO 8'h08
`define QAC_RST_CTRL_HI 8'h8c
`define QAC_RST_ALM_LO 8'h00
`define QAC_RST_ALM_HI 8'hff
`define QAC_RST_CAL 8'h00
`define QAC_CLK_NS 5
`define QAC_WAIT_NS 10000
`define QAC_BIT_NS 70000
`define QAC_OFS_NS 160000
`endif

// File: rtl/qac_fifo.v
// Byte FIFO between the slot layer and the command engine.
// Assumes one clock; clear drops all contents in one cycle.
`timescale 1ns/1ps
module qac_fifo #(
    parameter integer W = 8,
    parameter integer D = 8,
    parameter integer AW = 3
) (
    input wire clk_in,
    input wire resetn_in,
    input wire clear_in,
    input wire in_valid_in,
    input wire [W-1:0] in_data_in,
    output reg in_ready_out,
    output wire out_valid_out,
    output wire [W-1:0] out_data_out,
    input wire out_ready_in
);
    reg [W-1:0] mem_q [0:D-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire push = in_valid_in & in_ready_out;
    wire pop = out_valid_out & out_ready_in;
    wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
    assign out_data_out = mem_q[rp_q];

    always @(posedge clk_in) begin
        if (push) begin
            mem_q[wp_q] <= in_data_in;
        end
    end

    always @(posedge clk_in) begin
        if (!resetn_in || clear_in) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            in_ready_out <= 1'b1;
        end else begin
            if (push) begin
                wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
            end
            cnt_q <= cnt_d;
            // Registered ready keeps the port straight from a flop
            in_ready_out <= (cnt_d < D[AW:0]);
        end
    end
endmodule // qac_fifo

// File: rtl/qac_mem.v
// Thirty-two byte memory map with power-on defaults and registered read.
// Assumes write enables are already filtered by the engine.
`timescale 1ns/1ps
`include "qac_defines.vh"
module qac_mem #(
    parameter integer AW = 5
) (
    input wire clk_in,
    input wire resetn_in,
    input wire we_in,
    input wire [AW-1:0] waddr_in,
    input wire [7:0] wdata_in,
    input wire [AW-1:0] raddr_in,
    output reg [7:0] rdata_out
);
    reg [7:0] mem_q [0:(1<<AW)-1];
    integer i;

    function [7:0] rst_val;
        input [4:0] a;
        begin
            case (a[4:3])
                2'h0: rst_val = `QAC_RST_RESULT;
                2'h1: rst_val = a[0] ? `QAC_RST_CTRL_HI : `QAC_RST_CTRL_LO;
                2'h2: rst_val = a[0] ? `QAC_RST_ALM_HI : `QAC_RST_ALM_LO;
                default: rst_val = `QAC_RST_CAL;
            endcase
        end
    endfunction

    always @(posedge clk_in) begin
        if (!resetn_in) begin
            for (i = 0; i < (1<<AW); i = i + 1) begin
                mem_q[i] <= rst_val(i[4:0]);
            end
        end else if (we_in) begin
            mem_q[waddr_in] <= wdata_in;
        end
    end

    always @(posedge clk_in) begin
        rdata_out <= mem_q[raddr_in];
    end
endmodule // qac_mem

// File: verification/qac_engine_monitor.sv
// Port checker for the command engine, bound to qac_engine.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module qac_engine_monitor #(
    parameter integer WAIT_CYC = 4,
    parameter integer OFS_CYC = 5
) (
    input wire clk_in,
    input wire resetn_in,
    input wire bus_reset_in,
    input wire rx_ready_out,
    input wire rd_bit_out,
    input wire adc_start_out,
    input wire [1:0] adc_chan_out,
    input wire [4:0] adc_bits_out,
    input wire conv_busy_out
);
    reg [31:0] busy_cnt_q = 32'h0;
    reg [1:0] chan_q = 2'h0;
    reg seen_q = 1'b0;
    always @(posedge clk_in) begin
        busy_cnt_q <= conv_busy_out ? busy_cnt_q + 32'h1 : 32'h0;
        seen_q <= conv_busy_out && (seen_q || adc_start_out);
        chan_q <= adc_start_out ? adc_chan_out : chan_q;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_pulse;
        adc_start_out ##1 !adc_start_out;
    endsequence
    a_start_pulse: assert property (adc_start_out |-> s_pulse)
        else $error("start pulse too long");
    a_start_busy: assert property (adc_start_out |-> conv_busy_out)
        else $error("start while idle");
    a_bits_range: assert property (adc_start_out |->
        adc_bits_out >= 5'h01 && adc_bits_out <= 5'h10)
        else $error("resolution out of range");
    a_chan_order: assert property (adc_start_out && seen_q |->
        adc_chan_out > chan_q) else $error("channel order wrong");
    // Wait, eight preset cycles and the offset all precede a start
    a_start_delay: assert property (adc_start_out |->
        busy_cnt_q >= WAIT_CYC + 8 + OFS_CYC) else $error("start too early");
    a_poll_zero: assert property (
        conv_busy_out && $past(conv_busy_out, 3) |-> !rd_bit_out)
        else $error("poll not zero while busy");
    a_reset_idle: assert property ($rose(resetn_in) |->
        rd_bit_out && rx_ready_out && !conv_busy_out)
        else $error("outputs not idle after reset");
    a_bus_abort: assert property (bus_reset_in |->
        ##2 (!conv_busy_out && rx_ready_out))
        else $error("bus reset did not abort");
endmodule // qac_engine_monitor

bind qac_engine qac_engine_monitor #(
    .WAIT_CYC(WAIT_CYC), .OFS_CYC(OFS_CYC)
) u_mon (
    .clk_in(clk_in), .resetn_in(resetn_in), .bus_reset_in(bus_reset_in),
    .rx_ready_out(rx_ready_out), .rd_bit_out(rd_bit_out),
    .adc_start_out(adc_start_out), .adc_chan_out(adc_chan_out),
    .adc_bits_out(adc_bits_out), .conv_busy_out(conv_busy_out)
);

// File: verification/qac_adc_model.sv
// Converter stand-in answering each channel start with a result.
// Assumes the engine samples the result when the bit time ends.
`timescale 1ns/1ps
module qac_adc_model (
    input wire clk_in,
    input wire adc_start_in,
    input wire [1:0] adc_chan_in,
    output reg [15:0] result_out
);
    initial result_out = 16'hffff;
    // Channel number in both bytes exposes a swapped order
    always @(posedge clk_in) begin
        if (adc_start_in) begin
            result_out <= {6'h30, adc_chan_in, 6'h0c, adc_chan_in};
        end
    end
endmodule // qac_adc_model

// File: verification/quad_adc_memory_convert_commands_bench.sv
// Self-checking bench for the function-command engine.
// Assumes short wait, bit and offset counts to keep the run brief.
`timescale 1ns/1ps
`include "qac_defines.vh"
module quad_adc_memory_convert_commands_bench;
    reg clk_in = 1'b0;
    reg resetn_in = 1'b0;
    reg bus_reset_in = 1'b0;
    reg rx_valid_in = 1'b0;
    reg [7:0] rx_byte_in = 8'h00;
    reg rd_slot_in = 1'b0;
    wire rx_ready_out, rd_bit_out, adc_start_out, conv_busy_out;
    wire [1:0] adc_chan_out;
    wire [4:0] adc_bits_out;
    wire [15:0] adc_result_in;
    integer fails = 0;
    integer cmp_count = 0;
    integer a;
    reg [15:0] crc;
    reg [7:0] e;
    always #2.5 clk_in = ~clk_in;
    qac_engine #(.WAIT_CYC(4), .BIT_CYC(3), .OFS_CYC(5), .FIFO_DEPTH(8))
    u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
        .bus_reset_in(bus_reset_in), .rx_valid_in(rx_valid_in),
        .rx_byte_in(rx_byte_in), .rx_ready_out(rx_ready_out),
        .rd_slot_in(rd_slot_in), .rd_bit_out(rd_bit_out),
        .adc_result_in(adc_result_in), .adc_start_out(adc_start_out),
        .adc_chan_out(adc_chan_out), .adc_bits_out(adc_bits_out),
        .conv_busy_out(conv_busy_out));
    qac_adc_model u_adc (.clk_in(clk_in), .adc_start_in(adc_start_out),
        .adc_chan_in(adc_chan_out), .result_out(adc_result_in));
    task test_done;
        begin
            $display("compares %0d mismatches %0d", cmp_count, fails);
            if (fails == 0 && cmp_count > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask
    task chk(input [8*5-1:0] what, input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task hang;
        begin
            fails = fails + 1;
            test_done;
        end
    endtask
    function [15:0] upd(input [15:0] c, input [7:0] b);
        integer i;
        begin
            upd = c;
            for (i = 0; i < 8; i = i + 1) begin
                upd = (upd[0] ^ b[i]) ? (upd >> 1) ^ `QAC_CRC_POLY : upd >> 1;
            end
        end
    endfunction
    task send(input [7:0] b);
        integer i;
        begin
            for (i = 0; rx_ready_out !== 1'b1; i = i + 1) begin
                if (i == 200) hang;
                @(negedge clk_in);
            end
            rx_valid_in = 1'b1;
            rx_byte_in = b;
            crc = upd(crc, b);
            @(negedge clk_in);
            rx_valid_in = 1'b0;
            rx_byte_in = ~b;
            repeat (4) @(negedge clk_in);
        end
    endtask
    // Bit for a slot is shown before the slot pulse consumes it
    task rd(input integer n, input [15:0] exp);
        reg [15:0] v;
        integer i;
        begin
            v = 16'h0000;
            for (i = 0; i < n; i = i + 1) begin
                v[i] = rd_bit_out;
                rd_slot_in = 1'b1;
                @(negedge clk_in);
                rd_slot_in = 1'b0;
                repeat (4) @(negedge clk_in);
            end
            chk(n == 16 ? "crc" : "data", v, exp);
        end
    endtask
    task brst;
        begin
            bus_reset_in = 1'b1;
            @(negedge clk_in);
            bus_reset_in = 1'b0;
            repeat (4) @(negedge clk_in);
        end
    endtask
    task cmd3(input [7:0] c, input [7:0] x, input [7:0] y);
        begin
            crc = `QAC_CRC_INIT;
            send(c);
            send(x);
            send(y);
        end
    endtask
    task wr(input [7:0] ad, input [7:0] d, input [7:0] rb);
        begin
            cmd3(`QAC_CMD_WRITE, ad, 8'h00);
            send(d);
            rd(16, ~crc);
            rd(8, {8'h00, rb});
        end
    endtask
    task t_read;
        begin
            cmd3(`QAC_CMD_READ, 8'h06, 8'h00);
            for (a = 6; a < 16; a = a + 1) begin
                if (a == 8) begin
                    rd(16, ~crc);
                    crc = `QAC_CRC_INIT;
                end
                e = a < 8 ? 8'h00 : (a[0] ? 8'h8c : 8'h08);
                rd(8, {8'h00, e});
                crc = upd(crc, e);
            end
            rd(16, ~crc);
            brst;
        end
    endtask
    task t_write;
        begin
            wr(8'h08, 8'h05, 8'h05);
            crc = 16'h0009;
            send(8'h33);
            rd(16, ~crc);
            rd(8, 16'h0033);
            brst;
            wr(8'h00, 8'hab, 8'h00);
            brst;
            wr(8'h1f, 8'h77, 8'h00);
            rd(8, 16'h00ff);
            brst;
            wr(8'h1c, 8'h40, 8'h40);
            brst;
        end
    endtask
    task t_conv;
        begin
            cmd3(`QAC_CMD_CONVERT, 8'h05, 8'h1a);
            rd(16, ~crc);
            for (a = 0; conv_busy_out !== 1'b1; a = a + 1) begin
                if (a == 100) hang;
                @(negedge clk_in);
            end
            rd(1, 16'h0000);
            for (a = 0; conv_busy_out !== 1'b0; a = a + 1) begin
                if (a == 2000) hang;
                @(negedge clk_in);
            end
            rd(8, 16'h00ff);
            repeat (8) send(8'h00);
            chk("full", {15'h0, rx_ready_out}, 16'h0000);
            brst;
            chk("ready", {15'h0, rx_ready_out}, 16'h0001);
            cmd3(`QAC_CMD_READ, 8'h00, 8'h00);
            for (a = 0; a < 8; a = a + 1) begin
                e = a[1] ? 8'h00 : (a[0] ? 8'hc0 : 8'h30) | a[2:1];
                rd(8, {8'h00, e});
            end
            brst;
        end
    endtask
    initial begin
        repeat (20) @(negedge clk_in);
        resetn_in = 1'b1;
        @(negedge clk_in);
        t_read;
        t_write;
        t_conv;
        test_done;
    end
endmodule // quad_adc_memory_convert_commands_bench
